// ===== rtl/hpw_pkg.sv
// Constants and types shared by the hashed page table walker.
// Assumes entries are 64-bit words, bit 0 least significant, big-endian byte order.
package hpw_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int PA_W = 32;
  localparam int SEG_ID_W = 24;
  localparam int PIDX_W = 16;
  localparam int ABBR_W = 6;
  localparam int HASH_W = 19;
  localparam int MASK_W = 9;
  localparam int ENTRY_W = 64;
  localparam int GROUP_ENTRIES = 8;
  localparam int FAULT_REG_W = 32;

  // ***************************************************************
  // Entry layout
  // ***************************************************************
  localparam int E_V = 63;
  localparam int E_SEG_HI = 62;
  localparam int E_SEG_LO = 39;
  localparam int E_H = 38;
  localparam int E_ABBR_HI = 37;
  localparam int E_ABBR_LO = 32;
  localparam int E_R = 8;
  localparam int E_C = 7;
  localparam int E_W = 6;
  localparam int E_I = 5;
  localparam int E_PP_HI = 1;
  localparam int E_PP_LO = 0;
  localparam int ENTRY_SHIFT = 3;
  localparam int GROUP_SHIFT = 6;

  // Flag bytes inside an entry, and the bit to set in each
  localparam logic [2:0] R_BYTE_OFS = 3'h6;
  localparam logic [2:0] C_BYTE_OFS = 3'h7;
  localparam logic [7:0] R_BYTE_SET = 8'h01;
  localparam logic [7:0] C_BYTE_SET = 8'h80;

  // Memory attributes of every walker access: not write-through, cacheable, coherent
  localparam logic [2:0] MEM_ATTR_WALK = 3'h1;

  // ***************************************************************
  // Fault registers and reset values
  // ***************************************************************
  // Bit 1 counted from the most significant end
  localparam int PAGE_FAULT_BIT = 30;
  localparam logic [31:0] FAULT_REG_RST = 32'h00000000;
  localparam int ITU_STALL_CYCLES = 1;

  typedef enum logic [2:0] {
    HPW_IDLE, HPW_DEFER, HPW_READ, HPW_LOAD, HPW_RUPD, HPW_CUPD, HPW_FINISH, HPW_DONE
  } hpw_state_e;

endpackage : hpw_pkg

// ===== rtl/hpw_entry_match.sv
// Compares one translation entry against the virtual page number.
// Assumes a purely combinational use inside the walker.
`timescale 1ns/1ns
module hpw_entry_match
  import hpw_pkg::*;
(
  input wire logic [ENTRY_W-1:0] entry,
  input wire logic [SEG_ID_W-1:0] virtual_segment_id,
  input wire logic [ABBR_W-1:0] abbreviated_page_index,
  input wire logic secondary,
  output logic match
);
  import hpw_pkg::*;

  // ***************************************************************
  // Match: hash flag selects the group, entry must be valid
  // ***************************************************************
  always_comb begin
    match = (entry[E_H] == secondary) && entry[E_V]
      && (entry[E_SEG_HI:E_SEG_LO] == virtual_segment_id)
      && (entry[E_ABBR_HI:E_ABBR_LO] == abbreviated_page_index);
  end

endmodule : hpw_entry_match

// ===== rtl/hpw_walker.sv
// Hashed page table walker: searches both entry groups on a TLB miss,
// loads the TLB, updates referenced/changed flags, and serializes
// translation register accesses.
// Assumes requester, TLB, cache and dispatch logic all run on clk.
//
// Summary of operation
// - A miss in both ways of the indexed set starts a hardware table walk.
// - First form the 32-bit physical address of the primary entry group.
// - Every entry access carries memory attributes 0b001: cacheable burst line.
// - Primary match: hash 0, valid 1, segment id and page index equal.
// - Test up to eight primary entries, then move to the secondary group.
// - Secondary match: hash 1, valid 1, segment id and page index equal.
// - On a match load the TLB and set the referenced flag if needed.
// - Set changed flag only for a write passing protection; then finish.
// - No secondary match in eight entries raises instruction or data storage fault.
// - Data fault sets bit 1 of fault status; instruction fault of saved state.
// - Line zeroing on write-through or inhibited page may set referenced first.
// - Out-of-order misses wait until program flow requires the access.
// - Protection and zeroing alignment faults still found; changed flag left alone.
// - Translation register access stalls instruction translation one cycle.
// - Segment or instruction block register writes flush and hold fetch.
// - Instruction block register reads only serialize execution; fetch continues.
// - Victim way: invalid way first, otherwise the set's least recently used way.
`timescale 1ns/1ns
module hpw_walker
  import hpw_pkg::*;
#(
  parameter int ENTRIES = GROUP_ENTRIES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic miss_valid,
  input wire logic miss_out_of_order,
  input wire logic miss_required,
  input wire logic miss_instr,
  input wire logic miss_write,
  input wire logic miss_dcbz,
  input wire logic miss_key,
  input wire logic [hpw_pkg::SEG_ID_W-1:0] virtual_segment_id,
  input wire logic [hpw_pkg::PIDX_W-1:0] page_index,
  input wire logic [1:0] tlb_set_valid,
  input wire logic tlb_set_lru,
  input wire logic [hpw_pkg::PA_W-1:0] table_base,
  input wire logic [hpw_pkg::MASK_W-1:0] hash_mask,
  output logic mem_req,
  output logic mem_we,
  output logic [hpw_pkg::PA_W-1:0] mem_addr,
  output logic [2:0] memory_attribute_triple,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [hpw_pkg::ENTRY_W-1:0] mem_rdata,
  output logic tlb_load_valid,
  output logic tlb_load_way,
  output logic [hpw_pkg::ENTRY_W-1:0] translation_entry,
  output logic walk_busy,
  output logic walk_done,
  output logic walk_hit,
  output logic prot_fault,
  output logic align_fault,
  output logic instruction_storage_fault,
  output logic data_storage_fault,
  output logic [hpw_pkg::FAULT_REG_W-1:0] data_fault_status_reg,
  output logic [hpw_pkg::FAULT_REG_W-1:0] saved_machine_state_reg,
  input wire logic xlat_reg_access,
  input wire logic xlat_reg_write_fetch,
  input wire logic xlat_reg_read_ibat,
  input wire logic instr_complete,
  output logic itu_stall,
  output logic fetch_flush,
  output logic fetch_hold,
  output logic exec_serialize
);
  import hpw_pkg::*;

  localparam int IDX_W = $clog2(ENTRIES);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ENTRIES - 1);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [PA_W-1:0] group_addr(input logic [PA_W-1:0] base,
      input logic [MASK_W-1:0] mask, input logic [HASH_W-1:0] hash);
    group_addr = {base[31:25], base[24:16] | (hash[18:10] & mask), hash[9:0],
      6'h00};
  endfunction : group_addr

  function automatic logic prot_ok(input logic [1:0] pp, input logic key,
      input logic wr);
    if (wr) begin
      prot_ok = (pp == 2'h2) || (!key && (pp != 2'h3));
    end else begin
      prot_ok = !(key && (pp == 2'h0));
    end
  endfunction : prot_ok

  hpw_state_e st;
  logic [IDX_W-1:0] idx;
  logic secondary;
  logic [PA_W-1:0] grp_sec;
  logic [PA_W-1:0] ent_addr;
  logic [SEG_ID_W-1:0] seg_q;
  logic [ABBR_W-1:0] abbr_q;
  logic instr_q;
  logic write_q;
  logic dcbz_q;
  logic key_q;
  logic hit_now;
  logic start;
  logic [HASH_W-1:0] hash_p;
  logic [PA_W-1:0] pri_addr;
  logic perm_ok;
  logic zero_align;
  logic need_c;

  // ***************************************************************
  // Hash and address of the first entry
  // ***************************************************************
  assign hash_p = virtual_segment_id[HASH_W-1:0] ^ {3'h0, page_index};
  assign pri_addr = group_addr(table_base, hash_mask, hash_p);

  // Deferred out-of-order misses start only once flow needs them
  assign start = miss_valid && (!miss_out_of_order || miss_required)
    && ((st == HPW_IDLE) || (st == HPW_DEFER));

  hpw_entry_match u_match (
    .entry(mem_rdata),
    .virtual_segment_id(seg_q),
    .abbreviated_page_index(abbr_q),
    .secondary(secondary),
    .match(hit_now)
  );

  // Checks on the matched entry
  assign perm_ok = prot_ok(translation_entry[E_PP_HI:E_PP_LO], key_q, write_q);
  assign zero_align = dcbz_q && (translation_entry[E_W] || translation_entry[E_I]);
  // Protection and zeroing faults keep the changed flag from being set
  assign need_c = write_q && perm_ok && !zero_align && !translation_entry[E_C];

  // ***************************************************************
  // Walk sequencer and memory port
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= HPW_IDLE;
      idx <= '0;
      secondary <= 1'b0;
      grp_sec <= '0;
      ent_addr <= '0;
      seg_q <= '0;
      abbr_q <= '0;
      instr_q <= 1'b0;
      write_q <= 1'b0;
      dcbz_q <= 1'b0;
      key_q <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      memory_attribute_triple <= MEM_ATTR_WALK;
      mem_wdata <= 8'h00;
      translation_entry <= '0;
      walk_busy <= 1'b0;
      walk_done <= 1'b0;
      walk_hit <= 1'b0;
      prot_fault <= 1'b0;
      align_fault <= 1'b0;
    end else begin
      walk_done <= 1'b0;
      walk_hit <= 1'b0;
      prot_fault <= 1'b0;
      align_fault <= 1'b0;
      memory_attribute_triple <= MEM_ATTR_WALK;
      case (st)
        HPW_IDLE, HPW_DEFER: begin
          if (start) begin
            seg_q <= virtual_segment_id;
            abbr_q <= page_index[PIDX_W-1 -: ABBR_W];
            instr_q <= miss_instr;
            write_q <= miss_write;
            dcbz_q <= miss_dcbz;
            key_q <= miss_key;
            grp_sec <= group_addr(table_base, hash_mask, ~hash_p);
            secondary <= 1'b0;
            idx <= '0;
            ent_addr <= pri_addr;
            mem_addr <= pri_addr;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            walk_busy <= 1'b1;
            st <= HPW_READ;
          end else if (miss_valid && miss_out_of_order) begin
            st <= HPW_DEFER;
          end else begin
            st <= HPW_IDLE;
          end
        end
        HPW_READ: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            translation_entry <= mem_rdata;
            if (hit_now) begin
              st <= HPW_LOAD;
            end else if (idx != LAST_IDX) begin
              idx <= idx + 1'b1;
              ent_addr <= ent_addr + PA_W'(1 << ENTRY_SHIFT);
              mem_addr <= ent_addr + PA_W'(1 << ENTRY_SHIFT);
              mem_req <= 1'b1;
            end else if (!secondary) begin
              secondary <= 1'b1;
              idx <= '0;
              ent_addr <= grp_sec;
              mem_addr <= grp_sec;
              mem_req <= 1'b1;
            end else begin
              walk_done <= 1'b1;
              walk_busy <= 1'b0;
              st <= HPW_DONE;
            end
          end
        end
        HPW_LOAD: begin
          // Referenced flag set even ahead of alignment or protection faults
          if (!translation_entry[E_R]) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= {ent_addr[PA_W-1:ENTRY_SHIFT], R_BYTE_OFS};
            mem_wdata <= translation_entry[15:8] | R_BYTE_SET;
            st <= HPW_RUPD;
          end else if (need_c) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= {ent_addr[PA_W-1:ENTRY_SHIFT], C_BYTE_OFS};
            mem_wdata <= translation_entry[7:0] | C_BYTE_SET;
            st <= HPW_CUPD;
          end else begin
            st <= HPW_FINISH;
          end
        end
        HPW_RUPD: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            st <= HPW_LOAD;
            translation_entry[E_R] <= 1'b1;
          end
        end
        HPW_CUPD: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            translation_entry[E_C] <= 1'b1;
            st <= HPW_FINISH;
          end
        end
        HPW_FINISH: begin
          walk_done <= 1'b1;
          walk_hit <= 1'b1;
          prot_fault <= !perm_ok;
          align_fault <= zero_align;
          walk_busy <= 1'b0;
          st <= HPW_DONE;
        end
        default: begin
          // Wait for the retried access to retire its miss request
          if (!miss_valid) begin
            st <= HPW_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // TLB load and victim choice
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tlb_load_valid <= 1'b0;
      tlb_load_way <= 1'b0;
    end else begin
      tlb_load_valid <= (st == HPW_READ) && mem_ack && hit_now;
      if ((st == HPW_READ) && mem_ack && hit_now) begin
        if (!tlb_set_valid[0]) begin
          tlb_load_way <= 1'b0;
        end else if (!tlb_set_valid[1]) begin
          tlb_load_way <= 1'b1;
        end else begin
          tlb_load_way <= tlb_set_lru;
        end
      end
    end
  end

  // ***************************************************************
  // Page fault reporting
  // ***************************************************************
  logic miss_final;
  assign miss_final = (st == HPW_READ) && mem_ack && !hit_now && secondary
    && (idx == LAST_IDX);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instruction_storage_fault <= 1'b0;
      data_storage_fault <= 1'b0;
      data_fault_status_reg <= FAULT_REG_RST;
      saved_machine_state_reg <= FAULT_REG_RST;
    end else begin
      instruction_storage_fault <= miss_final && instr_q;
      data_storage_fault <= miss_final && !instr_q;
      if (miss_final && instr_q) begin
        saved_machine_state_reg[PAGE_FAULT_BIT] <= 1'b1;
      end
      if (miss_final && !instr_q) begin
        data_fault_status_reg[PAGE_FAULT_BIT] <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Translation register access serialization
  // ***************************************************************
  // Reads hold execution only, so fetch bandwidth is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      itu_stall <= 1'b0;
      fetch_flush <= 1'b0;
      fetch_hold <= 1'b0;
      exec_serialize <= 1'b0;
    end else begin
      itu_stall <= xlat_reg_access;
      fetch_flush <= xlat_reg_write_fetch;
      if (xlat_reg_write_fetch) begin
        fetch_hold <= 1'b1;
      end else if (instr_complete) begin
        fetch_hold <= 1'b0;
      end
      if (xlat_reg_read_ibat) begin
        exec_serialize <= 1'b1;
      end else if (instr_complete) begin
        exec_serialize <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_hit_seen;
    (st == HPW_READ) && mem_ack && hit_now;
  endsequence

  sequence s_load_then_busy;
    tlb_load_valid && walk_busy;
  endsequence

  AST_WALK_START: assert property (
    start |=> walk_busy && mem_req && !mem_we && (st == HPW_READ))
    else $error("walk did not start on miss");

  AST_FIRST_ADDR: assert property (
    start |=> mem_addr == $past(pri_addr))
    else $error("first entry address is not the primary group");

  AST_WALK_ATTR: assert property (
    mem_req |-> memory_attribute_triple == MEM_ATTR_WALK)
    else $error("walker access without cacheable attributes");

  AST_HIT_LOADS: assert property (
    s_hit_seen |=> s_load_then_busy)
    else $error("matching entry not loaded into the TLB");

  AST_GROUP_SWITCH: assert property (
    (st == HPW_READ) && mem_ack && !hit_now && !secondary && (idx == LAST_IDX)
    |=> secondary && (idx == '0) && (mem_addr == grp_sec) && mem_req)
    else $error("secondary group not searched after eight misses");

  AST_C_ONLY_WRITE: assert property (
    $rose(mem_we) && (mem_addr[2:0] == C_BYTE_OFS) |-> write_q && perm_ok && !zero_align)
    else $error("changed flag written without a permitted write");

  AST_FAULT_KIND: assert property (
    miss_final |=> (instruction_storage_fault == instr_q)
    && (data_storage_fault != instr_q) && walk_done && !walk_hit)
    else $error("page fault kind wrong after secondary miss");

  AST_FAULT_STATUS: assert property (
    data_storage_fault |-> data_fault_status_reg[PAGE_FAULT_BIT])
    else $error("data fault status bit not set");

  AST_DEFER_HOLD: assert property (
    (st == HPW_DEFER) && miss_valid && !miss_required |=> (st == HPW_DEFER) && !mem_req)
    else $error("deferred walk started early");

  AST_ITU_STALL: assert property (
    xlat_reg_access ##1 !xlat_reg_access |-> itu_stall ##1 !itu_stall)
    else $error("translation stall not exactly one cycle");

  AST_FETCH_HOLD: assert property (
    xlat_reg_write_fetch |=> fetch_flush && fetch_hold)
    else $error("fetch not flushed and held after register write");

  AST_READ_NO_HOLD: assert property (
    xlat_reg_read_ibat && !xlat_reg_write_fetch && !fetch_hold |=> !fetch_hold && exec_serialize)
    else $error("register read stalled fetch");

  AST_VICTIM: assert property (
    s_hit_seen and !tlb_set_valid[0] |=> tlb_load_valid && !tlb_load_way)
    else $error("invalid way not replaced first");

  AST_RETRY: assert property (
    walk_done |-> !walk_busy ##1 !walk_done)
    else $error("walk end not a single pulse with busy released");

endmodule : hpw_walker

// ===== dv/hpw_mem_model.sv
// Partner model: cache and memory that hold the hashed page table.
// Assumes one outstanding access; answers fast or with three wait cycles.
`timescale 1ns/1ns
module hpw_mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  // ***************************************************************
  // Entry store, keyed by entry address
  // ***************************************************************
  logic [63:0] mem [logic [31:0]];
  logic [63:0] w;
  logic [31:0] ea;
  int cnt;

  // Idle data toggles so a stale word is never mistaken for an answer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'h0;
      mem_rdata <= 64'hA5A5A5A5A5A5A5A5;
      cnt = 0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      cnt = 0;
    end else if (cnt < (slow ? 3 : 0)) begin
      cnt++;
      mem_rdata <= ~mem_rdata;
    end else begin
      ea = {mem_addr[31:3], 3'h0};
      w = mem.exists(ea) ? mem[ea] : 64'h0;
      if (mem_we) begin
        w[63 - 8 * int'(mem_addr[2:0]) -: 8] = mem_wdata;
        mem[ea] = w;
      end
      mem_rdata <= w;
      mem_ack <= 1'h1;
    end
  end
endmodule : hpw_mem_model

// ===== dv/hpw_walker_tb.sv
// Testbench of the walker: random page tables, reference outcome per walk.
// Assumes the memory partner model and the walker share clk.
`timescale 1ns/1ns
module hpw_walker_tb;
  import hpw_pkg::*;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic clk = '0, nrst = '0, slow = '0, mem_ack, mem_req, mem_we;
  logic miss_valid = '0, miss_out_of_order = '0, miss_required = '0, miss_instr = '0;
  logic miss_write = '0, miss_dcbz = '0, miss_key = '0, tlb_set_lru = '0, instr_complete = '0;
  logic xlat_reg_access = '0, xlat_reg_write_fetch = '0, xlat_reg_read_ibat = '0;
  logic [SEG_ID_W-1:0] virtual_segment_id = '0;
  logic [PIDX_W-1:0] page_index = '0;
  logic [1:0] tlb_set_valid = '0;
  logic [PA_W-1:0] table_base = '0, mem_addr;
  logic [MASK_W-1:0] hash_mask = '0;
  logic tlb_load_valid, tlb_load_way, walk_busy, walk_done, walk_hit, load_way;
  logic prot_fault, align_fault, instruction_storage_fault, data_storage_fault;
  logic itu_stall, fetch_flush, fetch_hold, exec_serialize;
  logic [2:0] memory_attribute_triple;
  logic [7:0] mem_wdata;
  logic [ENTRY_W-1:0] mem_rdata, translation_entry;
  logic [FAULT_REG_W-1:0] data_fault_status_reg, saved_machine_state_reg, exp_dfs, exp_sms;
  logic [40:0] q_seen[$], q_exp[$];
  int n_fail = 0, checks_done = 0, seed = 12575, n_load;
  int hps[6] = '{0, 7, 8, 15, 16, 16};

  hpw_walker i_hpw_walker (.*);
  hpw_mem_model i_hpw_mem_model (.*);

  always #2 clk = ~clk;

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic do_reset;
    nrst = '0;
    repeat (6) tick;
    nrst = '1;
    exp_dfs = FAULT_REG_RST;
    exp_sms = FAULT_REG_RST;
    chk(memory_attribute_triple, MEM_ATTR_WALK);
    chk({data_fault_status_reg, saved_machine_state_reg}, {exp_dfs, exp_sms});
    chk({walk_busy, mem_req}, 2'h0);
  endtask : do_reset

  function automatic logic [31:0] grp(input logic sec);
    logic [18:0] h;
    h = virtual_segment_id[18:0] ^ {3'h0, page_index};
    if (sec) h = ~h;
    return {table_base[31:25], table_base[24:16] | (h[18:10] & hash_mask), h[9:0], 6'h0};
  endfunction : grp

  // Monitor: every finished memory access, and TLB loads
  always @(posedge clk) begin
    if (nrst && mem_req && mem_ack) begin
      q_seen.push_back({mem_we, mem_addr, mem_wdata & {8{mem_we}}});
      chk(memory_attribute_triple, MEM_ATTR_WALK);
    end
    if (nrst && tlb_load_valid) begin
      n_load++;
      load_way = tlb_load_way;
    end
  end

  // ***************************************************************
  // One walk: hit at position hp (0..15), 16 means no match
  // ***************************************************************
  task automatic run_walk(input int hp, input logic ooo, input logic fi);
    logic [63:0] e, m;
    logic [31:0] a, r;
    int k;
    logic ok, al, hit;
    q_seen.delete();
    q_exp.delete();
    n_load = 0;
    i_hpw_mem_model.mem.delete(); // Fresh table, no stale translation survives
    r = $random(seed);
    virtual_segment_id = r[23:0];
    {miss_instr, miss_dcbz, miss_key, tlb_set_lru, tlb_set_valid, miss_write} = r[31:25];
    r = $random(seed);
    page_index = r[15:0];
    hash_mask = r[24:16];
    table_base = $random(seed);
    if (hp >= 16) miss_instr = fi;
    if (miss_instr) {miss_write, miss_dcbz} = 2'h0;
    miss_write = miss_write | miss_dcbz;
    miss_out_of_order = ooo;
    miss_required = !ooo;
    hit = hp < 16;
    for (int j = 0; j <= hp && j < 16; j++) begin
      a = grp(j > 7) + 32'(8 * (j % 8));
      q_exp.push_back({1'h0, a, 8'h0});
      e = {$random(seed), $random(seed)};
      e[E_V] = 1'h1;
      e[E_SEG_HI:E_SEG_LO] = virtual_segment_id;
      e[E_H] = j > 7;
      e[E_ABBR_HI:E_ABBR_LO] = page_index[15:10];
      k = $unsigned($random(seed)) % 4;
      // Each decoy breaks exactly one match condition
      if (j < hp) begin
        case (k)
          0: e[E_V] = 1'h0;
          1: e[E_H] = ~e[E_H];
          2: e[E_SEG_LO + $unsigned($random(seed)) % SEG_ID_W] ^= 1'h1;
          default: e[E_ABBR_LO + $unsigned($random(seed)) % ABBR_W] ^= 1'h1;
        endcase
      end
      i_hpw_mem_model.mem[a] = e; // Testbench writes the table only before the walk starts
      m = e;
    end
    ok = miss_write ? (m[1:0] == 2 || (!miss_key && m[1:0] != 3)) : !(miss_key && m[1:0] == 0);
    al = miss_dcbz && (m[E_W] || m[E_I]);
    if (hit && !m[E_R]) begin
      q_exp.push_back({1'h1, a + 32'h6, m[15:8] | R_BYTE_SET});
      m[E_R] = 1'h1;
    end
    if (hit && miss_write && ok && !al && !m[E_C]) begin
      q_exp.push_back({1'h1, a + 32'h7, m[7:0] | C_BYTE_SET});
      m[E_C] = 1'h1;
    end
    miss_valid = '1;
    if (ooo) begin
      repeat (5) tick;
      chk(q_seen.size() + mem_req, 0);
      miss_required = '1;
    end
    tick;
    for (k = 0; k < 400 && walk_done !== 1'h1; k++) begin
      chk(walk_busy, 1);
      tick;
    end
    chk({walk_hit, n_load != 0}, {hit, hit});
    chk({prot_fault, align_fault}, {hit && !ok, hit && al});
    chk(instruction_storage_fault, !hit && miss_instr);
    chk(data_storage_fault, !hit && !miss_instr);
    if (!hit && miss_instr) exp_sms[PAGE_FAULT_BIT] = 1'h1;
    if (!hit && !miss_instr) exp_dfs[PAGE_FAULT_BIT] = 1'h1;
    chk({data_fault_status_reg, saved_machine_state_reg}, {exp_dfs, exp_sms});
    if (hit) begin
      chk(load_way, !tlb_set_valid[0] ? 0 : !tlb_set_valid[1] ? 1 : tlb_set_lru);
      chk(translation_entry, m);
      chk(i_hpw_mem_model.mem[a], m);
    end
    miss_valid = '0;
    tick;
    chk(q_seen.size(), q_exp.size());
    foreach (q_exp[j]) chk(q_seen[j], q_exp[j]);
  endtask : run_walk

  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial begin
    do_reset;
    for (int i = 0; i < 60; i++) begin
      slow = i[0];
      run_walk(i < 6 ? hps[i] : $unsigned($random(seed)) % 17, i % 5 == 4, i[0]);
    end
    do_reset;
    xlat_reg_access = '1;
    tick;
    xlat_reg_access = '0;
    chk(itu_stall, 1);
    xlat_reg_write_fetch = '1;
    tick;
    xlat_reg_write_fetch = '0;
    chk({itu_stall, fetch_flush, fetch_hold}, 3'h3);
    tick;
    chk({fetch_flush, fetch_hold}, 2'h1);
    instr_complete = '1;
    tick;
    instr_complete = '0;
    xlat_reg_read_ibat = '1;
    chk(fetch_hold, 0);
    tick;
    xlat_reg_read_ibat = '0;
    chk({fetch_flush, fetch_hold, exec_serialize}, 3'h1);
    instr_complete = '1;
    tick;
    instr_complete = '0;
    chk(exec_serialize, 0);
    test_done;
  end

  // Sixty walks of at most a few hundred cycles each fit well inside this
  initial begin
    #400000;
    n_fail++;
    test_done;
  end
endmodule : hpw_walker_tb
